// ===== dv/oad_decoder_asserts.sv
// Purpose: concurrent checks on the opcode decoder ports
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to every decoder instance below the module
`timescale 1ns/10ps
`default_nettype none

module oad_decoder_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // byte side
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic byte_ready,
  // result side
  input wire logic dec_valid,
  input wire logic dec_ready,
  input wire oad_pkg::oad_op_t dec_op,
  input wire logic dec_word,
  input wire logic dec_count_cl,
  input wire logic dec_repeat,
  input wire logic dec_repeat_z,
  input wire logic [2:0] dec_len,
  input wire logic [1:0] dec_mod,
  input wire logic [2:0] dec_rm,
  input wire logic [15:0] dec_disp,
  input wire logic [15:0] dec_imm
);
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic took;
  logic gave;

  // bytes taken since the last result left, saturating like the length
  assign took = byte_valid && byte_ready;
  assign gave = dec_valid && dec_ready;
  assign cnt_d = gave ? 3'h0 : (took && cnt_q != 3'h7) ? cnt_q + 3'h1 : cnt_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  take_clear_a: assert property (gave |=> !dec_valid && byte_ready
    && dec_len == 3'h0) else $error("result not cleared after take");
  result_hold_a: assert property (dec_valid && !dec_ready |=> dec_valid
    && $stable(dec_op) && $stable(dec_len) && $stable(dec_imm))
    else $error("result changed while stalled");
  len_count_a: assert property (dec_valid |-> dec_len == cnt_q)
    else $error("length differs from bytes taken");
  class_gap_a: assert property (!byte_ready && !dec_valid |=> dec_valid)
    else $error("class cycle not followed by result");
  one_byte_a: assert property (dec_valid && !dec_repeat && dec_op inside {
    oad_pkg::OP_ASCII_ADJUST_SUB, oad_pkg::OP_DECIMAL_ADJUST_SUB,
    oad_pkg::OP_SIGN_EXTEND_BYTE, oad_pkg::OP_SIGN_EXTEND_WORD,
    oad_pkg::OP_STRING_SCAN, oad_pkg::OP_STRING_COMPARE,
    oad_pkg::OP_STRING_LOAD, oad_pkg::OP_STRING_STORE}
    |-> dec_len == 3'h1) else $error("one-byte opcode with wrong length");
  adj_pair_a: assert property (dec_valid && dec_op inside {
    oad_pkg::OP_ASCII_ADJUST_MULT, oad_pkg::OP_ASCII_ADJUST_DIV}
    |-> dec_imm == 16'h000A && (dec_repeat || dec_len == 3'h2))
    else $error("adjust pair decoded wrongly");
  ret_imm_a: assert property (dec_valid && !dec_repeat
    && dec_op == oad_pkg::OP_RETURN_NEAR_IMM |-> dec_len == 3'h3)
    else $error("return with immediate has wrong length");
  grp3_reg_a: assert property (dec_valid && !dec_repeat && dec_mod == 2'h3
    && dec_op inside {oad_pkg::OP_MULTIPLY, oad_pkg::OP_SIGNED_MULTIPLY,
    oad_pkg::OP_DIVIDE, oad_pkg::OP_SIGNED_DIVIDE, oad_pkg::OP_INVERT}
    |-> dec_len == 3'h2 && dec_imm == 16'h0000)
    else $error("register form of group three has extra bytes");
  count_src_a: assert property (dec_valid && dec_count_cl |-> dec_op inside {
    oad_pkg::OP_LEFT_SHIFT, oad_pkg::OP_LOGICAL_RIGHT_SHIFT,
    oad_pkg::OP_ARITH_RIGHT_SHIFT, oad_pkg::OP_ROTATE_LEFT,
    oad_pkg::OP_ROTATE_RIGHT, oad_pkg::OP_ROTATE_LEFT_CARRY,
    oad_pkg::OP_ROTATE_RIGHT_CARRY}) else $error("count source on non-shift");
  no_width_a: assert property (dec_valid && dec_op inside {
    oad_pkg::OP_SIGN_EXTEND_BYTE, oad_pkg::OP_SIGN_EXTEND_WORD,
    oad_pkg::OP_RETURN_NEAR, oad_pkg::OP_RETURN_NEAR_IMM,
    oad_pkg::OP_RETURN_FAR} |-> !dec_word) else $error("width on fixed op");
endmodule : oad_decoder_chk

bind oad_decoder oad_decoder_chk chk (.core_clk(core_clk), .nrst(nrst),
  .byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready),
  .dec_valid(dec_valid), .dec_ready(dec_ready), .dec_op(dec_op),
  .dec_word(dec_word), .dec_count_cl(dec_count_cl), .dec_repeat(dec_repeat),
  .dec_repeat_z(dec_repeat_z), .dec_len(dec_len), .dec_mod(dec_mod),
  .dec_rm(dec_rm), .dec_disp(dec_disp), .dec_imm(dec_imm));

`default_nettype wire

// ===== dv/oad_decoder_tb.sv
// Purpose: self-checking bench for the opcode decoder
// Assumes: inputs change on the falling edge
// Notes: expected fields come from the opcode tables
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end

module oad_decoder_tb;
  logic core_clk, nrst, byte_valid, byte_ready, dec_valid, dec_ready;
  logic dec_word, dec_count_cl, dec_repeat, dec_repeat_z;
  logic [7:0] byte_data;
  logic [2:0] dec_len, dec_rm;
  logic [1:0] dec_mod;
  logic [15:0] dec_disp, dec_imm;
  oad_pkg::oad_op_t dec_op;
  int fails = 0;
  int checked = 0;
  logic e_cl = 1'b0, e_rep = 1'b0, e_z = 1'b0;
  logic [15:0] e_disp = 16'h0000;
  logic [2:0] e_rm = 3'h0;
  int e_stall = 0;

  oad_feeder feed (.core_clk(core_clk), .byte_ready(byte_ready),
    .byte_valid(byte_valid), .byte_data(byte_data));
  oad_decoder dut (.core_clk(core_clk), .nrst(nrst), .byte_valid(byte_valid),
    .byte_data(byte_data), .byte_ready(byte_ready), .dec_valid(dec_valid),
    .dec_ready(dec_ready), .dec_op(dec_op), .dec_word(dec_word),
    .dec_count_cl(dec_count_cl), .dec_repeat(dec_repeat),
    .dec_repeat_z(dec_repeat_z), .dec_len(dec_len), .dec_mod(dec_mod),
    .dec_rm(dec_rm), .dec_disp(dec_disp), .dec_imm(dec_imm));

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic final_report;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // send n bytes (first in bits 7:0), judge the result, then take it
  task automatic issue(input int n, input logic [47:0] bs,
    input oad_pkg::oad_op_t op, input logic [2:0] len, input logic w,
    input logic [15:0] imm);
    int k;
    for (k = 0; k < n; k++) begin
      feed.push(bs[8*k +: 8]);
    end
    for (k = 0; k < 40 && dec_valid !== 1'b1; k++) begin
      @(negedge core_clk);
    end
    if (k == 40) begin
      fails++;
      final_report();
    end
    `CHK("op", op, dec_op)
    `CHK("len", len, dec_len)
    `CHK("word", w, dec_word)
    `CHK("imm", imm, dec_imm)
    `CHK("disp", e_disp, dec_disp)
    `CHK("rm", e_rm, dec_rm)
    `CHK("count", e_cl, dec_count_cl)
    `CHK("rep", e_rep, dec_repeat)
    `CHK("z", e_z, dec_repeat_z)
    repeat (e_stall) begin
      @(negedge core_clk);
      `CHK("hold", op, dec_op)
    end
    dec_ready = 1'b1;
    @(negedge core_clk);
    dec_ready = 1'b0;
    `CHK("cleared", 1'b0, dec_valid)
    `CHK("ready", 1'b1, byte_ready)
  endtask : issue

  task automatic t_adjust;
    issue(1, 48'h3F, oad_pkg::OP_ASCII_ADJUST_SUB, 3'h1, 1'b0, 16'h0);
    issue(1, 48'h2F, oad_pkg::OP_DECIMAL_ADJUST_SUB, 3'h1, 1'b0, 16'h0);
    issue(2, 48'h0AD4, oad_pkg::OP_ASCII_ADJUST_MULT, 3'h2, 1'b0, 16'h000A);
    issue(2, 48'h0AD5, oad_pkg::OP_ASCII_ADJUST_DIV, 3'h2, 1'b0, 16'h000A);
    issue(1, 48'h98, oad_pkg::OP_SIGN_EXTEND_BYTE, 3'h1, 1'b0, 16'h0);
    issue(1, 48'h99, oad_pkg::OP_SIGN_EXTEND_WORD, 3'h1, 1'b0, 16'h0);
    // codes the decoder must leave unclassified, with full length
    issue(2, 48'h0BD4, oad_pkg::OP_NONE, 3'h2, 1'b0, 16'h000B);
    issue(2, 48'hF0D0, oad_pkg::OP_NONE, 3'h2, 1'b0, 16'h0);
    issue(2, 48'hC8F6, oad_pkg::OP_NONE, 3'h2, 1'b0, 16'h0);
    issue(1, 48'h90, oad_pkg::OP_NONE, 3'h1, 1'b0, 16'h0);
  endtask : t_adjust

  task automatic t_grp3;
    for (int i = 0; i < 2; i++) begin
      issue(2, {40'h0D0, 7'h7B, i[0]}, oad_pkg::OP_INVERT, 3'h2, i[0],
        16'h0);
      issue(2, {40'h0E0, 7'h7B, i[0]}, oad_pkg::OP_MULTIPLY, 3'h2, i[0], 16'h0);
      issue(2, {40'h0E8, 7'h7B, i[0]}, oad_pkg::OP_SIGNED_MULTIPLY, 3'h2, i[0], 16'h0);
      issue(2, {40'h0F0, 7'h7B, i[0]}, oad_pkg::OP_DIVIDE, 3'h2, i[0], 16'h0);
      issue(2, {40'h0F8, 7'h7B, i[0]}, oad_pkg::OP_SIGNED_DIVIDE, 3'h2, i[0], 16'h0);
    end
    issue(3, 48'h55C0F6, oad_pkg::OP_TEST, 3'h3, 1'b0, 16'h0055);
    e_rm = 3'h3;
    issue(4, 48'h1234C3F7, oad_pkg::OP_TEST, 3'h4, 1'b1, 16'h1234);
    e_rm = 3'h0;
    e_disp = 16'h5678;
    issue(4, 48'h5678A0F7, oad_pkg::OP_MULTIPLY, 3'h4, 1'b1, 16'h0);
    e_disp = 16'h1234;
    e_rm = 3'h6;
    issue(5, 48'h66123406F6, oad_pkg::OP_TEST, 3'h5, 1'b0, 16'h0066);
    e_disp = 16'h0000;
    e_rm = 3'h0;
  endtask : t_grp3

  task automatic t_shift;
    for (int j = 0; j < 4; j++) begin
      e_cl = j[1];
      issue(2, {40'h0C0, 6'h34, j[1:0]}, oad_pkg::OP_ROTATE_LEFT, 3'h2, j[0], 16'h0);
      issue(2, {40'h0C8, 6'h34, j[1:0]}, oad_pkg::OP_ROTATE_RIGHT, 3'h2, j[0], 16'h0);
      issue(2, {40'h0D0, 6'h34, j[1:0]}, oad_pkg::OP_ROTATE_LEFT_CARRY, 3'h2, j[0], 16'h0);
      issue(2, {40'h0D8, 6'h34, j[1:0]}, oad_pkg::OP_ROTATE_RIGHT_CARRY, 3'h2, j[0], 16'h0);
      issue(2, {40'h0E0, 6'h34, j[1:0]}, oad_pkg::OP_LEFT_SHIFT, 3'h2, j[0], 16'h0);
      issue(2, {40'h0E8, 6'h34, j[1:0]}, oad_pkg::OP_LOGICAL_RIGHT_SHIFT, 3'h2, j[0], 16'h0);
      issue(2, {40'h0F8, 6'h34, j[1:0]}, oad_pkg::OP_ARITH_RIGHT_SHIFT, 3'h2, j[0], 16'h0);
    end
    e_cl = 1'b0;
  endtask : t_shift

  task automatic t_test_forms;
    issue(2, 48'hC084, oad_pkg::OP_TEST, 3'h2, 1'b0, 16'h0);
    issue(2, 48'h55A8, oad_pkg::OP_TEST, 3'h2, 1'b0, 16'h0055);
    issue(3, 48'h1234A9, oad_pkg::OP_TEST, 3'h3, 1'b1, 16'h1234);
  endtask : t_test_forms

  task automatic t_string;
    e_rep = 1'b1;
    e_z = 1'b1;
    issue(2, 48'hA4F3, oad_pkg::OP_STRING_MOVE, 3'h2, 1'b0, 16'h0);
    // two prefixes: the condition bit of the last one is kept
    issue(3, 48'hA5F3F2, oad_pkg::OP_STRING_MOVE, 3'h3, 1'b1, 16'h0);
    e_z = 1'b0;
    issue(2, 48'hA7F2, oad_pkg::OP_STRING_COMPARE, 3'h2, 1'b1, 16'h0);
    e_rep = 1'b0;
    issue(1, 48'hAE, oad_pkg::OP_STRING_SCAN, 3'h1, 1'b0, 16'h0);
    issue(1, 48'hA6, oad_pkg::OP_STRING_COMPARE, 3'h1, 1'b0, 16'h0);
    issue(1, 48'hAD, oad_pkg::OP_STRING_LOAD, 3'h1, 1'b1, 16'h0);
    issue(1, 48'hAA, oad_pkg::OP_STRING_STORE, 3'h1, 1'b0, 16'h0);
  endtask : t_string

  task automatic t_return;
    e_stall = 3;
    issue(3, 48'h1234C2, oad_pkg::OP_RETURN_NEAR_IMM, 3'h3, 1'b0, 16'h1234);
    e_stall = 0;
    issue(1, 48'hC3, oad_pkg::OP_RETURN_NEAR, 3'h1, 1'b0, 16'h0);
    issue(1, 48'hCB, oad_pkg::OP_RETURN_FAR, 3'h1, 1'b0, 16'h0);
  endtask : t_return

  // reset, then every scenario back to back
  initial begin
    nrst = 1'b0;
    dec_ready = 1'b0;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    nrst = 1'b1;
    `CHK("rst_valid", 1'b0, dec_valid)
    `CHK("rst_op", oad_pkg::OP_NONE, dec_op)
    t_adjust();
    t_grp3();
    t_shift();
    t_test_forms();
    t_string();
    t_return();
    final_report();
  end
endmodule : oad_decoder_tb

`default_nettype wire

// ===== dv/oad_feeder.sv
// Purpose: prefetch queue model offering instruction bytes
// Assumes: bench pushes whole instructions after reset
// Notes: the data line toggles when no byte is offered
`timescale 1ns/10ps
`default_nettype none

module oad_feeder (
  // clock
  input wire logic core_clk,
  // byte handshake
  input wire logic byte_ready,
  output logic byte_valid,
  output logic [7:0] byte_data
);
  logic [7:0] fifo [$];
  logic took;

  initial begin
    byte_valid = 1'b0;
    byte_data = 8'h00;
    took = 1'b0;
  end

  task automatic push(input logic [7:0] b);
    fifo.push_back(b);
  endtask : push

  // a byte leaves the queue only on the edge that takes it
  always @(posedge core_clk) begin
    took = byte_valid && byte_ready;
    if (took) begin
      void'(fifo.pop_front());
    end
  end

  // offer next byte off the edge; idle line shows a changing pattern
  always @(negedge core_clk) begin
    if (took || !byte_valid) begin
      if (fifo.size() > 0) begin
        byte_valid = 1'b1;
        byte_data = fifo[0];
      end else begin
        byte_valid = 1'b0;
        byte_data = ~byte_data;
      end
    end
  end
endmodule : oad_feeder

`default_nettype wire

// ===== hw/oad_decoder.sv
// Purpose: byte-serial opcode decoder for arithmetic, logic and string ops
// Assumes: one instruction byte offered per cycle with valid/ready
// Notes: result stands until taken; unknown opcodes report OP_NONE
`timescale 1ns/10ps
`default_nettype none
`include "oad_params.svh"

module oad_decoder (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // instruction bytes from the prefetch queue
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  output logic byte_ready,
  // decoded instruction to the execution unit
  output logic dec_valid,
  input wire logic dec_ready,
  output oad_pkg::oad_op_t dec_op,
  output logic dec_word,
  output logic dec_count_cl,
  output logic dec_repeat,
  output logic dec_repeat_z,
  output logic [2:0] dec_len,
  output logic [1:0] dec_mod,
  output logic [2:0] dec_rm,
  output logic [15:0] dec_disp,
  output logic [15:0] dec_imm
);

  // state and working registers
  oad_pkg::oad_state_t st_q;
  oad_pkg::oad_state_t st_d;
  oad_pkg::oad_op_t op_q;
  oad_pkg::oad_op_t cls_op;
  logic [7:0] opc_q;
  logic [7:0] opc_d;
  logic [7:0] modrm_q;
  logic [7:0] modrm_d;
  logic [15:0] disp_q;
  logic [15:0] disp_d;
  logic [15:0] imm_q;
  logic [15:0] imm_d;
  logic [1:0] dleft_q;
  logic [1:0] dleft_d;
  logic [1:0] ileft_q;
  logic [1:0] ileft_d;
  logic dfirst_q;
  logic dfirst_d;
  logic ifirst_q;
  logic ifirst_d;
  logic [2:0] len_q;
  logic [2:0] len_d;
  logic rep_q;
  logic rep_d;
  logic repz_q;
  logic repz_d;
  logic word_q;
  logic word_d;
  logic cnt_q;
  logic cnt_d;

  // handshake terms
  wire accept;
  wire restart;
  wire in_op;
  wire in_modrm;
  wire in_disp;
  wire in_imm;
  wire in_class;

  assign byte_ready = (st_q != oad_pkg::ST_CLASS) &&
                      (st_q != oad_pkg::ST_DONE);
  assign dec_valid = (st_q == oad_pkg::ST_DONE);
  assign accept = byte_valid && byte_ready;
  assign restart = dec_valid && dec_ready;
  assign in_op = accept && (st_q == oad_pkg::ST_OPCODE);
  assign in_modrm = accept && (st_q == oad_pkg::ST_MODRM);
  assign in_disp = accept && (st_q == oad_pkg::ST_DISP);
  assign in_imm = accept && (st_q == oad_pkg::ST_IMM);
  assign in_class = (st_q == oad_pkg::ST_CLASS);

  // first-byte recognition on the incoming byte
  wire b_rep;
  wire b_grp3;
  wire b_shift;
  wire b_test_rm;
  wire b_test_acc;
  wire b_ret_imm;
  wire b_adj_two;
  wire b_modrm;
  wire [1:0] b_imm_n;

  assign b_rep = byte_data[7:1] == `OAD_PAT_REPEAT;
  assign b_grp3 = byte_data[7:1] == `OAD_PAT_GRP3;
  assign b_shift = byte_data[7:2] == `OAD_PAT_SHIFT;
  assign b_test_rm = byte_data[7:1] == `OAD_PAT_TEST_RM;
  assign b_test_acc = byte_data[7:1] == `OAD_PAT_TEST_ACC;
  assign b_ret_imm = byte_data == `OAD_OPC_RTN_NEAR_IMM;
  assign b_adj_two = (byte_data == `OAD_OPC_ADJ_MULT) ||
                     (byte_data == `OAD_OPC_ADJ_DIV);
  assign b_modrm = b_grp3 || b_shift || b_test_rm;

  // immediate bytes known from the opcode alone
  assign b_imm_n = b_ret_imm ? 2'h2 :
                   b_adj_two ? 2'h1 :
                   b_test_acc ? (byte_data[`OAD_BIT_W] ? 2'h2 : 2'h1) :
                   2'h0;

  // addressing-byte recognition on the incoming byte
  wire m_direct;
  wire [1:0] m_disp_n;
  wire [1:0] m_imm_n;
  wire o_grp3;

  assign o_grp3 = opc_q[7:1] == `OAD_PAT_GRP3;
  assign m_direct = (byte_data[7:6] == `OAD_MOD_MEM) &&
                    (byte_data[2:0] == `OAD_RM_DIRECT);
  assign m_disp_n = (byte_data[7:6] == `OAD_MOD_D8) ? 2'h1 :
                    (byte_data[7:6] == `OAD_MOD_D16) ? 2'h2 :
                    m_direct ? 2'h2 : 2'h0;
  // only the test form of group three carries immediate data
  assign m_imm_n = (o_grp3 && byte_data[5:3] == `OAD_MID_0) ?
                   (opc_q[`OAD_BIT_W] ? 2'h2 : 2'h1) : 2'h0;

  // sequencing through prefix, opcode, addressing, displacement, data
  always_comb begin
    st_d = st_q;
    case (st_q)
      oad_pkg::ST_OPCODE: begin
        if (accept && !b_rep) begin
          if (b_modrm) begin
            st_d = oad_pkg::ST_MODRM;
          end else if (b_imm_n != 2'h0) begin
            st_d = oad_pkg::ST_IMM;
          end else begin
            st_d = oad_pkg::ST_CLASS;
          end
        end
      end
      oad_pkg::ST_MODRM: begin
        if (accept) begin
          if (m_disp_n != 2'h0) begin
            st_d = oad_pkg::ST_DISP;
          end else if (m_imm_n != 2'h0) begin
            st_d = oad_pkg::ST_IMM;
          end else begin
            st_d = oad_pkg::ST_CLASS;
          end
        end
      end
      oad_pkg::ST_DISP: begin
        if (accept && dleft_q == 2'h1) begin
          if (ileft_q != 2'h0) begin
            st_d = oad_pkg::ST_IMM;
          end else begin
            st_d = oad_pkg::ST_CLASS;
          end
        end
      end
      oad_pkg::ST_IMM: begin
        if (accept && ileft_q == 2'h1) begin
          st_d = oad_pkg::ST_CLASS;
        end
      end
      oad_pkg::ST_CLASS: begin
        st_d = oad_pkg::ST_DONE;
      end
      oad_pkg::ST_DONE: begin
        if (dec_ready) begin
          st_d = oad_pkg::ST_OPCODE;
        end
      end
      default: begin
        st_d = oad_pkg::ST_OPCODE;
      end
    endcase
  end

  // next values of the captured bytes and counters
  assign opc_d = restart ? 8'h00 : in_op && !b_rep ? byte_data : opc_q;
  assign modrm_d = restart ? 8'h00 : in_modrm ? byte_data : modrm_q;
  assign dleft_d = in_modrm ? m_disp_n :
                   in_disp ? dleft_q - 2'h1 : dleft_q;
  assign ileft_d = in_op && !b_rep ? b_imm_n :
                   in_modrm ? m_imm_n :
                   in_imm ? ileft_q - 2'h1 : ileft_q;
  assign dfirst_d = in_modrm ? 1'b1 : in_disp ? 1'b0 : dfirst_q;
  assign ifirst_d = (in_op || in_modrm) ? 1'b1 :
                    in_imm ? 1'b0 : ifirst_q;

  // one displacement byte is sign extended; two arrive low then high
  assign disp_d = restart ? 16'h0000 :
                  in_disp && dfirst_q ? {{8{byte_data[7]}}, byte_data} :
                  in_disp ? {byte_data, disp_q[7:0]} : disp_q;
  // immediate arrives low byte first, high byte second
  assign imm_d = restart ? 16'h0000 :
                 in_imm && ifirst_q ? {8'h00, byte_data} :
                 in_imm ? {byte_data, imm_q[7:0]} : imm_q;

  // every accepted byte, prefix included, counts toward the length, which stops at OAD_LEN_MAX
  assign len_d = restart ? 3'h0 :
                 accept && len_q != `OAD_LEN_MAX ? len_q + 3'h1 :
                 len_q;

  // repeat prefix held with its condition bit until the result is taken
  assign rep_d = restart ? 1'b0 : in_op && b_rep ? 1'b1 : rep_q;
  assign repz_d = restart ? 1'b0 :
                  in_op && b_rep ? byte_data[`OAD_BIT_Z] :
                  repz_q;

  // classification of the collected opcode and addressing byte
  wire [2:0] mid;
  wire o_shift;
  wire o_test_rm;
  wire o_test_acc;
  wire o_base_ok;
  wire o_has_w;
  oad_pkg::oad_op_t grp3_op;
  oad_pkg::oad_op_t shift_op;
  oad_pkg::oad_op_t str_op;

  assign mid = modrm_q[5:3];
  assign o_shift = opc_q[7:2] == `OAD_PAT_SHIFT;
  assign o_test_rm = opc_q[7:1] == `OAD_PAT_TEST_RM;
  assign o_test_acc = opc_q[7:1] == `OAD_PAT_TEST_ACC;
  assign o_base_ok = imm_q[7:0] == `OAD_OPC_ADJ_BASE;

  // group three middle field: test, invert, multiply, divide
  assign grp3_op =
    (mid == `OAD_MID_0) ? oad_pkg::OP_TEST :
    (mid == `OAD_MID_2) ? oad_pkg::OP_INVERT :
    (mid == `OAD_MID_4) ? oad_pkg::OP_MULTIPLY :
    (mid == `OAD_MID_5) ? oad_pkg::OP_SIGNED_MULTIPLY :
    (mid == `OAD_MID_6) ? oad_pkg::OP_DIVIDE :
    (mid == `OAD_MID_7) ? oad_pkg::OP_SIGNED_DIVIDE :
    oad_pkg::OP_NONE;

  // shift group middle field; code 110 is left undefined
  assign shift_op =
    (mid == `OAD_MID_0) ? oad_pkg::OP_ROTATE_LEFT :
    (mid == `OAD_MID_1) ? oad_pkg::OP_ROTATE_RIGHT :
    (mid == `OAD_MID_2) ? oad_pkg::OP_ROTATE_LEFT_CARRY :
    (mid == `OAD_MID_3) ? oad_pkg::OP_ROTATE_RIGHT_CARRY :
    (mid == `OAD_MID_4) ? oad_pkg::OP_LEFT_SHIFT :
    (mid == `OAD_MID_5) ? oad_pkg::OP_LOGICAL_RIGHT_SHIFT :
    (mid == `OAD_MID_7) ? oad_pkg::OP_ARITH_RIGHT_SHIFT :
    oad_pkg::OP_NONE;

  // string primitives
  assign str_op =
    (opc_q[7:1] == `OAD_PAT_STR_MOVE) ? oad_pkg::OP_STRING_MOVE :
    (opc_q[7:1] == `OAD_PAT_STR_CMP) ? oad_pkg::OP_STRING_COMPARE :
    (opc_q[7:1] == `OAD_PAT_STR_SCAN) ? oad_pkg::OP_STRING_SCAN :
    (opc_q[7:1] == `OAD_PAT_STR_LOAD) ? oad_pkg::OP_STRING_LOAD :
    (opc_q[7:1] == `OAD_PAT_STR_STORE) ? oad_pkg::OP_STRING_STORE :
    oad_pkg::OP_NONE;

  // whole-opcode selection
  assign cls_op =
    (opc_q == `OAD_OPC_ADJ_SUB_ASCII) ?
      oad_pkg::OP_ASCII_ADJUST_SUB :
    (opc_q == `OAD_OPC_ADJ_SUB_DEC) ?
      oad_pkg::OP_DECIMAL_ADJUST_SUB :
    (opc_q == `OAD_OPC_ADJ_MULT && o_base_ok) ?
      oad_pkg::OP_ASCII_ADJUST_MULT :
    (opc_q == `OAD_OPC_ADJ_DIV && o_base_ok) ?
      oad_pkg::OP_ASCII_ADJUST_DIV :
    (opc_q == `OAD_OPC_EXT_BYTE) ?
      oad_pkg::OP_SIGN_EXTEND_BYTE :
    (opc_q == `OAD_OPC_EXT_WORD) ?
      oad_pkg::OP_SIGN_EXTEND_WORD :
    (opc_q == `OAD_OPC_RTN_NEAR_IMM) ?
      oad_pkg::OP_RETURN_NEAR_IMM :
    (opc_q == `OAD_OPC_RTN_NEAR) ?
      oad_pkg::OP_RETURN_NEAR :
    (opc_q == `OAD_OPC_RTN_FAR) ?
      oad_pkg::OP_RETURN_FAR :
    (o_test_rm || o_test_acc) ? oad_pkg::OP_TEST :
    o_grp3 ? grp3_op :
    o_shift ? shift_op :
    str_op;

  // width bit applies only to forms that carry one
  assign o_has_w = o_grp3 || o_shift || o_test_rm || o_test_acc ||
                   (str_op != oad_pkg::OP_NONE);
  assign word_d = restart ? 1'b0 :
                  in_class ? o_has_w && opc_q[`OAD_BIT_W] :
                  word_q;
  // count source: one when v is clear, count register low byte when set
  assign cnt_d = restart ? 1'b0 :
                 in_class ? o_shift && opc_q[`OAD_BIT_V] :
                 cnt_q;

  // state register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= oad_pkg::ST_OPCODE;
    end else begin
      st_q <= st_d;
    end
  end

  // captured bytes
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      opc_q <= 8'h00;
      modrm_q <= 8'h00;
      disp_q <= 16'h0000;
      imm_q <= 16'h0000;
    end else begin
      opc_q <= opc_d;
      modrm_q <= modrm_d;
      disp_q <= disp_d;
      imm_q <= imm_d;
    end
  end

  // byte counters and ordering flags
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dleft_q <= 2'h0;
      ileft_q <= 2'h0;
      dfirst_q <= 1'b0;
      ifirst_q <= 1'b0;
      len_q <= 3'h0;
    end else begin
      dleft_q <= dleft_d;
      ileft_q <= ileft_d;
      dfirst_q <= dfirst_d;
      ifirst_q <= ifirst_d;
      len_q <= len_d;
    end
  end

  // result attributes
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rep_q <= 1'b0;
      repz_q <= 1'b0;
      word_q <= 1'b0;
      cnt_q <= 1'b0;
      op_q <= oad_pkg::OP_NONE;
    end else begin
      rep_q <= rep_d;
      repz_q <= repz_d;
      word_q <= word_d;
      cnt_q <= cnt_d;
      op_q <= in_class ? cls_op : restart ? oad_pkg::OP_NONE : op_q;
    end
  end

  // outputs straight from flip-flops
  assign dec_op = op_q;
  assign dec_word = word_q;
  assign dec_count_cl = cnt_q;
  assign dec_repeat = rep_q;
  assign dec_repeat_z = repz_q;
  assign dec_len = len_q;
  assign dec_mod = modrm_q[7:6];
  assign dec_rm = modrm_q[2:0];
  assign dec_disp = disp_q;
  assign dec_imm = imm_q;

endmodule : oad_decoder
`default_nettype wire

// ===== hw/oad_params.svh
// Purpose: opcode values, field positions and counts for the decoder
// Assumes: bytes arrive in program order from the prefetch queue
// Notes: byte patterns with a w, v or z bit are matched on bits 7:1 or 7:2
`ifndef OAD_PARAMS_SVH
`define OAD_PARAMS_SVH
// whole-byte opcodes
`define OAD_OPC_ADJ_SUB_ASCII 8'h3F
`define OAD_OPC_ADJ_SUB_DEC 8'h2F
`define OAD_OPC_ADJ_MULT 8'hD4
`define OAD_OPC_ADJ_DIV 8'hD5
`define OAD_OPC_ADJ_BASE 8'h0A
`define OAD_OPC_EXT_BYTE 8'h98
`define OAD_OPC_EXT_WORD 8'h99
`define OAD_OPC_RTN_NEAR_IMM 8'hC2
`define OAD_OPC_RTN_NEAR 8'hC3
`define OAD_OPC_RTN_FAR 8'hCB
// patterns on bits 7:1
`define OAD_PAT_GRP3 7'h7B
`define OAD_PAT_TEST_RM 7'h42
`define OAD_PAT_TEST_ACC 7'h54
`define OAD_PAT_REPEAT 7'h79
`define OAD_PAT_STR_MOVE 7'h52
`define OAD_PAT_STR_CMP 7'h53
`define OAD_PAT_STR_SCAN 7'h57
`define OAD_PAT_STR_LOAD 7'h56
`define OAD_PAT_STR_STORE 7'h55
// pattern on bits 7:2
`define OAD_PAT_SHIFT 6'h34
// field positions
`define OAD_BIT_W 0
`define OAD_BIT_V 1
`define OAD_BIT_Z 0
`define OAD_MOD_MEM 2'h0
`define OAD_MOD_D8 2'h1
`define OAD_MOD_D16 2'h2
`define OAD_RM_DIRECT 3'h6
// middle field codes
`define OAD_MID_0 3'h0
`define OAD_MID_1 3'h1
`define OAD_MID_2 3'h2
`define OAD_MID_3 3'h3
`define OAD_MID_4 3'h4
`define OAD_MID_5 3'h5
`define OAD_MID_6 3'h6
`define OAD_MID_7 3'h7
// length counter ceiling
`define OAD_LEN_MAX 3'h7
`endif

// ===== hw/oad_pkg.sv
// Purpose: types shared by the opcode decoder
// Assumes: nothing
// Notes: operation codes are left to the tool
package oad_pkg;
  // decoder sequencing states
  typedef enum logic [2:0] {
    ST_OPCODE, ST_MODRM, ST_DISP, ST_IMM, ST_CLASS, ST_DONE
  } oad_state_t;
  // decoded operation classes
  typedef enum logic [4:0] {
    OP_NONE, OP_ASCII_ADJUST_SUB, OP_DECIMAL_ADJUST_SUB,
    OP_MULTIPLY, OP_SIGNED_MULTIPLY, OP_ASCII_ADJUST_MULT,
    OP_DIVIDE, OP_SIGNED_DIVIDE, OP_ASCII_ADJUST_DIV,
    OP_SIGN_EXTEND_BYTE, OP_SIGN_EXTEND_WORD, OP_INVERT, OP_TEST,
    OP_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT, OP_ARITH_RIGHT_SHIFT,
    OP_ROTATE_LEFT, OP_ROTATE_RIGHT, OP_ROTATE_LEFT_CARRY,
    OP_ROTATE_RIGHT_CARRY, OP_STRING_MOVE, OP_STRING_COMPARE,
    OP_STRING_SCAN, OP_STRING_LOAD, OP_STRING_STORE,
    OP_RETURN_NEAR, OP_RETURN_NEAR_IMM, OP_RETURN_FAR
  } oad_op_t;
endpackage : oad_pkg
